// ===== verilog/acl_link_status.sv
// Status, modem slot and FIFO level logic of a serial audio link controller.
// Assumes bit_clk and sdata_in come from the codec, and the FIFO levels come from core_clk logic.
`timescale 1ns/1ps

module acl_link_status
    import acl_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Serial link.
    input wire logic bit_clk,
    input wire logic sdata_in,
    output logic sync,
    output logic sdata_out,
    // FIFO side.
    input wire logic [7:0] rx_level,
    input wire logic [7:0] tx_free,
    output logic rx_flush,
    output logic tx_flush,
    // Interrupt.
    output logic irq
);

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Pin synchronisers.
    // The third bit clock stage only serves edge detection; nothing but the second stage reads the first.
    // The bit clock must stay below a quarter of core_clk, or neighbouring edges would merge.
    logic bclk_s1_r, bclk_s2_r, bclk_s3_r, sdin_s1_r, sdin_s2_r;
    always_ff @(posedge core_clk) begin
        bclk_s1_r <= bit_clk;
        bclk_s2_r <= bclk_s1_r;
        bclk_s3_r <= bclk_s2_r;
        sdin_s1_r <= sdata_in;
        sdin_s2_r <= sdin_s1_r;
    end
    wire rise_e = bclk_s2_r & ~bclk_s3_r;
    wire fall_e = ~bclk_s2_r & bclk_s3_r;

    // Register state.
    acl_cmd_t cmd_r;
    acl_stat_t stat_r;
    logic modem_ena_r;
    logic [ACL_MODEM_BITS-1:0] modem_ctl_r, modem_stat_r;
    logic [7:0] rx_level_r, tx_free_r;
    logic [ACL_INT_BITS-1:0] int_stat_r, int_mask_r;
    logic [31:0] rdata_r;
    logic rx_flush_r, tx_flush_r, irq_r;

    // Frame position and per-frame flags.
    logic [3:0] slot_r, rx_slot_r;
    logic [4:0] bit_r, rx_bit_r;
    logic frame_cmd_r, frame_rw_r, frame_modem_r;
    logic sync_r, sdout_r;
    logic [18:0] rx_shift_r;
    logic [15:0] tag_r;

    // Bus decode.
    wire wr_cmd = reg_wr & hit(reg_addr, ACL_OFS_CMD);
    wire wr_mctl = reg_wr & hit(reg_addr, ACL_OFS_MCTL);
    wire wr_fifo = reg_wr & hit(reg_addr, ACL_OFS_FIFO);
    wire wr_istat = reg_wr & hit(reg_addr, ACL_OFS_INT_STAT);
    wire wr_imask = reg_wr & hit(reg_addr, ACL_OFS_INT_MASK);
    wire acl_cmd_t cmd_w = acl_cmd_t'(reg_wdata);
    wire read_req = wr_cmd & cmd_w.en & cmd_w.rw;

    // Transmit sequencing.
    wire last_bit = (bit_r == 5'h00);
    wire frame_end = rise_e & last_bit & (slot_r == ACL_LAST_SLOT);
    wire cmd_en_nxt = (wr_cmd & cmd_w.en) ? 1'b1 : ((frame_end & frame_cmd_r) ? 1'b0 : cmd_r.en);
    wire modem_ena_nxt = (wr_mctl & reg_wdata[ACL_POS_MODEM_ENA]) ? 1'b1
                       : ((frame_end & frame_modem_r) ? 1'b0 : modem_ena_r);
    wire [15:0] out_tag = {frame_cmd_r | frame_modem_r, frame_cmd_r, frame_cmd_r & ~frame_rw_r, 9'h000,
                           frame_modem_r, 3'h0};
    wire [19:0] s1_word = {cmd_r.rw, cmd_r.index, 12'h000};
    wire [19:0] s2_word = {cmd_r.wdata, 4'h0};
    wire [19:0] cur_word = (slot_r == 4'h0) ? {4'h0, out_tag}
                         : (slot_r == 4'h1 && frame_cmd_r) ? s1_word
                         : (slot_r == 4'h2 && frame_cmd_r && !frame_rw_r) ? s2_word
                         : (slot_r == ACL_LAST_SLOT && frame_modem_r) ? modem_ctl_r
                         : 20'h00000;
    wire out_bit = cur_word[bit_r];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            slot_r <= 4'h0;
            bit_r <= ACL_TAG_TOP;
            rx_slot_r <= 4'h0;
            rx_bit_r <= ACL_TAG_TOP;
            sync_r <= 1'b0;
            sdout_r <= 1'b0;
        end else if (rise_e) begin
            sync_r <= (slot_r == 4'h0);
            sdout_r <= out_bit;
            rx_slot_r <= slot_r;
            rx_bit_r <= bit_r;
            bit_r <= !last_bit ? bit_r - 5'h01 : ACL_SLOT_TOP;
            if (last_bit) begin
                slot_r <= (slot_r == ACL_LAST_SLOT) ? 4'h0 : slot_r + 4'h1;
                if (slot_r == ACL_LAST_SLOT) begin
                    bit_r <= ACL_TAG_TOP;
                end
            end
        end
    end

    // A frame takes its flags when it starts; later writes wait for the following frame, but one whose kind is in flight alters its unsent slots and is lost.
    // A command written in the very cycle that closes a frame brings its own direction into the
    // next tag, since otherwise the tag and slot 1 would disagree about read or write.
    wire rw_nxt = wr_cmd ? cmd_w.rw : cmd_r.rw;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            frame_cmd_r <= 1'b0;
            frame_rw_r <= 1'b0;
            frame_modem_r <= 1'b0;
        end else if (frame_end) begin
            frame_cmd_r <= cmd_en_nxt;
            frame_rw_r <= rw_nxt;
            frame_modem_r <= modem_ena_nxt;
        end
    end

    // Receive side, sampled on the falling bit clock edge.
    wire [19:0] rx_word = {rx_shift_r, sdin_s2_r};
    wire rx_end = fall_e & (rx_bit_r == 5'h00);
    wire tag_end = rx_end & (rx_slot_r == 4'h0);
    wire idx_load = rx_end & (rx_slot_r == 4'h1) & tag_r[ACL_TAG_SLOT1];
    wire rb_load = rx_end & (rx_slot_r == 4'h2) & tag_r[ACL_TAG_SLOT1] & tag_r[ACL_TAG_SLOT2];
    wire modem_load = rx_end & (rx_slot_r == ACL_LAST_SLOT) & tag_r[ACL_TAG_SLOT12];
    wire ready_rise = tag_end & rx_word[ACL_TAG_READY] & ~stat_r.ready;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_shift_r <= 19'h00000;
            tag_r <= 16'h0000;
        end else if (fall_e) begin
            rx_shift_r <= rx_word[18:0];
            if (tag_end) begin
                tag_r <= rx_word[15:0];
            end
        end
    end

    // A new read request beats returning data for the old one, since that data is stale.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stat_r <= '0;
        end else begin
            if (tag_end) begin
                stat_r.ready <= rx_word[ACL_TAG_READY];
            end
            if (idx_load) begin
                stat_r.index <= rx_word[ACL_S1_IDX_LSB +: 7];
            end
            if (rb_load) begin
                stat_r.data <= rx_word[ACL_S2_DATA_LSB +: 16];
            end
            if (read_req) begin
                stat_r.valid <= 1'b0;
            end else if (rb_load) begin
                stat_r.valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            modem_stat_r <= 20'h00000;
        end else if (modem_load) begin
            modem_stat_r <= rx_word;
        end
    end

    // Software registers.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd_r <= '0;
            modem_ena_r <= 1'b0;
            modem_ctl_r <= 20'h00000;
            int_mask_r <= '0;
        end else begin
            cmd_r.en <= cmd_en_nxt;
            modem_ena_r <= modem_ena_nxt;
            if (wr_cmd) begin
                cmd_r.pdown <= cmd_w.pdown;
                cmd_r.wdata <= cmd_w.wdata;
                cmd_r.rw <= cmd_w.rw;
                cmd_r.index <= cmd_w.index;
            end
            if (wr_mctl) begin
                modem_ctl_r <= reg_wdata[ACL_MODEM_BITS-1:0];
            end
            if (wr_imask) begin
                int_mask_r <= reg_wdata[ACL_INT_BITS-1:0];
            end
        end
    end

    // Interrupt status: an event in the clearing cycle still sets its bit.
    wire [ACL_INT_BITS-1:0] int_ev = {ready_rise, rb_load & ~read_req, modem_load};
    wire [ACL_INT_BITS-1:0] int_clr = wr_istat ? reg_wdata[ACL_INT_BITS-1:0] : '0;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            int_stat_r <= '0;
            irq_r <= 1'b0;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_ev;
            irq_r <= |(int_stat_r & int_mask_r);
        end
    end

    // FIFO levels and purge pulses.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_level_r <= ACL_RX_LEVEL_RST;
            tx_free_r <= ACL_TX_FREE_RST;
            rx_flush_r <= 1'b0;
            tx_flush_r <= 1'b0;
        end else begin
            rx_level_r <= rx_level;
            tx_free_r <= tx_free;
            rx_flush_r <= wr_fifo & reg_wdata[ACL_POS_RX_FLUSH];
            tx_flush_r <= wr_fifo & reg_wdata[ACL_POS_TX_FLUSH];
        end
    end

    // Read data; the purge bits are write-only and always read as zero.
    wire [31:0] rd_mux = hit(reg_addr, ACL_OFS_CMD) ? 32'(cmd_r)
                       : hit(reg_addr, ACL_OFS_STAT) ? 32'(stat_r)
                       : hit(reg_addr, ACL_OFS_MCTL) ? {11'h000, modem_ena_r, modem_ctl_r}
                       : hit(reg_addr, ACL_OFS_MSTAT) ? {12'h000, modem_stat_r}
                       : hit(reg_addr, ACL_OFS_FIFO) ? {16'h0000, rx_level_r, tx_free_r}
                       : hit(reg_addr, ACL_OFS_INT_STAT) ? {29'h0, int_stat_r}
                       : hit(reg_addr, ACL_OFS_INT_MASK) ? {29'h0, int_mask_r}
                       : 32'h00000000;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_r <= 32'h00000000;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_r;
    assign sync = sync_r;
    assign sdata_out = sdout_r;
    assign rx_flush = rx_flush_r;
    assign tx_flush = tx_flush_r;
    assign irq = irq_r;

    // Checks.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    ready_mirror_a: assert property (tag_end |=> stat_r.ready == $past(rx_word[ACL_TAG_READY]))
        else $error("codec ready does not follow the received tag");
    rb_clear_a: assert property (read_req |=> !stat_r.valid)
        else $error("read request did not clear readback valid");
    rb_set_a: assert property (rb_load && !read_req |=> stat_r.valid && int_stat_r[ACL_INT_READBACK])
        else $error("returned data did not set readback valid");
    index_cap_a: assert property (idx_load |=> stat_r.index == $past(rx_word[ACL_S1_IDX_LSB +: 7]))
        else $error("echoed index not captured");
    rb_hold_a: assert property (stat_r.valid && !rb_load |=> $stable(stat_r.data))
        else $error("valid readback data changed");
    slot12_out_a: assert property (rise_e && slot_r == ACL_LAST_SLOT && frame_modem_r
                                   |=> sdout_r == $past(modem_ctl_r[bit_r]))
        else $error("slot 12 bit differs from the modem control word");
    modem_clear_a: assert property (frame_end && frame_modem_r && !wr_mctl |=> !modem_ena_r)
        else $error("modem send bit not cleared after its frame");
    modem_store_a: assert property (modem_load |=> modem_stat_r == $past(rx_word))
        else $error("modem status not stored");
    modem_irq_a: assert property (modem_load |=> int_stat_r[ACL_INT_MODEM]
                                  ##1 (irq_r || !$past(int_mask_r[ACL_INT_MODEM])))
        else $error("modem update did not raise the interrupt");
    rx_purge_a: assert property (wr_fifo && reg_wdata[ACL_POS_RX_FLUSH] |=> rx_flush
                                 ##1 (!rx_flush || $past(wr_fifo && reg_wdata[ACL_POS_RX_FLUSH])))
        else $error("receive purge pulse wrong");
    tx_purge_a: assert property (wr_fifo && reg_wdata[ACL_POS_TX_FLUSH] |=> tx_flush
                                 ##1 (!tx_flush || $past(wr_fifo && reg_wdata[ACL_POS_TX_FLUSH])))
        else $error("transmit purge pulse wrong");
    level_rst_a: assert property ($past(rst) |-> rx_level_r == ACL_RX_LEVEL_RST && tx_free_r == ACL_TX_FREE_RST)
        else $error("FIFO level fields wrong after reset");
    level_track_a: assert property (1'b1 |=> tx_free_r == $past(tx_free) && rx_level_r == $past(rx_level))
        else $error("FIFO level fields do not track the FIFOs");
    rw_bit_a: assert property (rise_e && slot_r == 4'h1 && bit_r == ACL_SLOT_TOP && frame_cmd_r
                               |=> sdout_r == $past(cmd_r.rw))
        else $error("slot 1 command bit differs from read/write flag");
    cmd_clear_a: assert property (frame_end && frame_cmd_r && !wr_cmd |=> !cmd_r.en)
        else $error("command enable not cleared after its frame");
    // Tag bits must match the frame flags, or the codec would read slots that were never filled.
    tag_cmd_a: assert property (rise_e && slot_r == 4'h0 && bit_r == 5'(ACL_TAG_SLOT1)
                                |=> sdout_r == $past(frame_cmd_r))
        else $error("slot 1 tag bit differs from the command flag");
    tag_write_a: assert property (rise_e && slot_r == 4'h0 && bit_r == 5'(ACL_TAG_SLOT2)
                                  |=> sdout_r == $past(frame_cmd_r && !frame_rw_r))
        else $error("slot 2 tag bit differs from the write flag");
    tag_modem_a: assert property (rise_e && slot_r == 4'h0 && bit_r == 5'(ACL_TAG_SLOT12)
                                  |=> sdout_r == $past(frame_modem_r))
        else $error("slot 12 tag bit differs from the modem flag");
    slot12_idle_a: assert property (rise_e && slot_r == ACL_LAST_SLOT && !frame_modem_r
                                    |=> !sdout_r)
        else $error("slot 12 not zero without a modem send");
    valid_keep_a: assert property (stat_r.valid && !read_req |=> stat_r.valid)
        else $error("readback valid cleared without a read request");
    rx_purge_only_a: assert property (!(wr_fifo && reg_wdata[ACL_POS_RX_FLUSH]) |=> !rx_flush)
        else $error("receive purge without a purge write");
    tx_purge_only_a: assert property (!(wr_fifo && reg_wdata[ACL_POS_TX_FLUSH]) |=> !tx_flush)
        else $error("transmit purge without a purge write");
    modem_hold_a: assert property (!modem_load |=> $stable(modem_stat_r))
        else $error("modem status changed without a slot 12 update");

    readback_c: cover property (read_req ##[1:1000] rb_load);
    modem_send_c: cover property (frame_end && frame_modem_r);
    modem_rx_c: cover property (modem_load ##1 irq_r);
    purge_c: cover property (rx_flush && tx_flush);
    write_cmd_c: cover property (frame_end && frame_cmd_r && !frame_rw_r);

endmodule

// ===== verilog/acl_pkg.sv
// Shared constants and types for the serial link status, modem slot and FIFO level block.
// Assumes a 32-bit register port with byte offsets and a 20-bit slot frame of 12 data slots.
package acl_pkg;

    // Register byte offsets.
    localparam logic [7:0] ACL_OFS_CMD = 8'h20;
    localparam logic [7:0] ACL_OFS_STAT = 8'h24;
    localparam logic [7:0] ACL_OFS_MCTL = 8'h28;
    localparam logic [7:0] ACL_OFS_MSTAT = 8'h2C;
    localparam logic [7:0] ACL_OFS_FIFO = 8'h30;
    localparam logic [7:0] ACL_OFS_INT_STAT = 8'h40;
    localparam logic [7:0] ACL_OFS_INT_MASK = 8'h44;

    // Field positions.
    localparam int ACL_POS_MODEM_ENA = 20;
    localparam int ACL_MODEM_BITS = 20;
    localparam int ACL_POS_RX_FLUSH = 31;
    localparam int ACL_POS_TX_FLUSH = 30;
    localparam int ACL_TAG_READY = 15;
    localparam int ACL_TAG_FRAME = 15;
    localparam int ACL_TAG_SLOT1 = 14;
    localparam int ACL_TAG_SLOT2 = 13;
    localparam int ACL_TAG_SLOT12 = 3;
    localparam int ACL_S1_RW = 19;
    localparam int ACL_S1_IDX_LSB = 12;
    localparam int ACL_S2_DATA_LSB = 4;

    // Frame geometry.
    localparam logic [3:0] ACL_LAST_SLOT = 4'hC;
    localparam logic [4:0] ACL_TAG_TOP = 5'h0F;
    localparam logic [4:0] ACL_SLOT_TOP = 5'h13;

    // Interrupt status bits.
    localparam int ACL_INT_BITS = 3;
    localparam int ACL_INT_MODEM = 0;
    localparam int ACL_INT_READBACK = 1;
    localparam int ACL_INT_READY = 2;

    // Values after reset.
    localparam logic [7:0] ACL_RX_LEVEL_RST = 8'h00;
    localparam logic [7:0] ACL_TX_FREE_RST = 8'h80;

    typedef struct packed {
        logic [5:0] rsvd;
        logic pdown;
        logic en;
        logic [15:0] wdata;
        logic rw;
        logic [6:0] index;
    } acl_cmd_t;

    typedef struct packed {
        logic [6:0] rsvd;
        logic ready;
        logic valid;
        logic [6:0] index;
        logic [15:0] data;
    } acl_stat_t;

endpackage

// ===== sim/acl_codec_model.sv
// Behavioural codec on the far side of the serial link.
// Assumes the controller drives slot bits after bit clock rises and samples them on falls.
`timescale 1ns/1ps

module acl_codec_model (
    // Link pins.
    output logic bit_clk,
    output logic sdata_in,
    input wire logic sync,
    input wire logic sdata_out,
    // Bench controls.
    input wire logic ready,
    input wire logic mdm_req,
    input wire logic [19:0] mdm_stat,
    // Observed outbound frame.
    output logic [255:0] out_frame,
    output int frames
);
    logic [7:0] pos;
    logic sync_d;
    logic rd_req;
    logic [6:0] idx;
    logic [255:0] shift_r;
    logic [255:0] in_frame;

    initial begin
        bit_clk = 1'b0;
        sdata_in = 1'b0;
        pos = 8'h00;
        sync_d = 1'b0;
        shift_r = 256'h0;
        in_frame = 256'h0;
        out_frame = 256'h0;
        frames = 0;
    end

    // The bit clock runs free, as a codec's crystal clock does.
    always #100 bit_clk = ~bit_clk;

    // Outbound bits are taken one bit time late, when they have surely settled.
    always @(posedge bit_clk) begin
        pos = (sync && !sync_d) ? 8'h01 : pos + 8'h01;
        sync_d = sync;
        shift_r = {shift_r[254:0], sdata_out};
        if (pos == 8'h00) begin
            out_frame = shift_r;
            frames = frames + 1;
            rd_req = shift_r[254] && shift_r[239];
            idx = shift_r[238:232];
            in_frame = {ready, rd_req, rd_req, 9'h000, mdm_req, 3'h0,
                        rd_req ? {1'b0, idx, 12'h000} : 20'h00000,
                        rd_req ? {idx, 2'h2, idx, 4'h0} : 20'h00000,
                        180'h0, mdm_req ? mdm_stat : 20'h00000};
        end
        sdata_in <= in_frame[8'hFF - pos];
    end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the link status, modem slot and FIFO level block.
// Assumes the codec model makes the bit clock and answers read commands in the following frame.
`timescale 1ns/1ps

module testbench;
    import acl_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic bit_clk, sdata_in, sync, sdata_out, rx_flush, tx_flush, irq;
    logic [7:0] rx_level = 8'h00;
    logic [7:0] tx_free = 8'h80;
    logic ready = 1'b0;
    logic mdm_req = 1'b0;
    logic [19:0] mdm_stat = 20'h00000;
    logic [255:0] out_frame;
    logic [6:0] idx;
    int frames;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    acl_link_status i_acl_link_status (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_clk(bit_clk), .sdata_in(sdata_in),
        .sync(sync), .sdata_out(sdata_out), .rx_level(rx_level), .tx_free(tx_free), .rx_flush(rx_flush),
        .tx_flush(tx_flush), .irq(irq));
    acl_codec_model i_acl_codec_model (.bit_clk(bit_clk), .sdata_in(sdata_in), .sync(sync), .sdata_out(sdata_out),
        .ready(ready), .mdm_req(mdm_req), .mdm_stat(mdm_stat), .out_frame(out_frame), .frames(frames));

    always #12.5 core_clk = ~core_clk;

    task automatic conclude();
        $display("Checks made: %0d, mismatches: %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hung wait would otherwise stall the run; the frames used need about 40000 cycles.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 70000) begin
            fail_count = fail_count + 1;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // The read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
        @(posedge core_clk);
    endtask

    task automatic flush_chk(input logic [31:0] d, input logic [1:0] exp);
        wr(ACL_OFS_FIFO, d);
        #1;
        check({30'h0, rx_flush, tx_flush}, {30'h0, exp});
        @(posedge core_clk);
        #1;
        check({30'h0, rx_flush, tx_flush}, 32'h0);
        @(posedge core_clk);
    endtask

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge core_clk);
        #1;
        check({31'h0, irq}, {31'h0, exp});
        @(posedge core_clk);
    endtask

    task automatic wait_frames(input int n);
        int t;
        repeat (n) begin
            t = frames;
            while (frames == t) @(posedge core_clk);
        end
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd_chk(ACL_OFS_FIFO, 32'h0000_0080);
        rd_chk(ACL_OFS_MSTAT, 32'h0);
        rd_chk(ACL_OFS_STAT, 32'h0);
        rx_level <= 8'h37;
        tx_free <= 8'h12;
        repeat (2) @(posedge core_clk);
        rd_chk(ACL_OFS_FIFO, 32'h0000_3712);
        rd_chk(8'h3C, 32'h0);
        flush_chk(32'h8000_0000, 2'b10);
        flush_chk(32'h4000_0000, 2'b01);
        rd_chk(ACL_OFS_FIFO, 32'h0000_3712);
        wr(ACL_OFS_INT_MASK, 32'h0);
        ready <= 1'b1;
        wait_frames(2);
        rd_chk(ACL_OFS_STAT, 32'h0100_0000);
        rd_chk(ACL_OFS_INT_STAT, 32'h0000_0004);
        irq_chk(1'b0);
        wr(ACL_OFS_INT_MASK, 32'h0000_0007);
        irq_chk(1'b1);
        wr(ACL_OFS_INT_STAT, 32'h0000_0004);
        irq_chk(1'b0);
        // Two reads in a row, so the second request clears a valid flag that is really set.
        for (int i = 0; i < 2; i++) begin
            idx = (i == 0) ? 7'h2A : 7'h15;
            wait_frames(1);
            wr(ACL_OFS_CMD, 32'h0100_0080 | {25'h0, idx});
            // The old index and data stay behind a cleared valid flag.
            rd_chk(ACL_OFS_STAT, (i == 0) ? 32'h0100_0000 : {9'h002, 7'h2A, 7'h2A, 2'h2, 7'h2A});
            wait_frames(2);
            check({16'h0, out_frame[255:240]}, 32'h0000_C000);
            check({12'h0, out_frame[239:220]}, {12'h0, 1'b1, idx, 12'h000});
            wait_frames(1);
            rd_chk(ACL_OFS_STAT, {7'h00, 1'b1, 1'b1, idx, idx, 2'h2, idx});
            rd_chk(ACL_OFS_CMD, 32'h0000_0080 | {25'h0, idx});
            irq_chk(1'b1);
            wr(ACL_OFS_INT_STAT, 32'h0000_0002);
        end
        wait_frames(1);
        wr(ACL_OFS_CMD, 32'h01BE_EF11);
        wait_frames(2);
        check({16'h0, out_frame[255:240]}, 32'h0000_E000);
        check({12'h0, out_frame[239:220]}, 32'h0001_1000);
        check({12'h0, out_frame[219:200]}, 32'h000B_EEF0);
        wait_frames(1);
        check({16'h0, out_frame[255:240]}, 32'h0);
        wr(ACL_OFS_MCTL, 32'h0005_A5A5);
        @(posedge core_clk);
        wr(ACL_OFS_MCTL, 32'h0015_A5A5);
        wait_frames(2);
        check({16'h0, out_frame[255:240]}, 32'h0000_8008);
        check({12'h0, out_frame[19:0]}, 32'h0005_A5A5);
        rd_chk(ACL_OFS_MCTL, 32'h0005_A5A5);
        mdm_stat <= 20'hC3A51;
        mdm_req <= 1'b1;
        wait_frames(2);
        mdm_req <= 1'b0;
        wait_frames(1);
        rd_chk(ACL_OFS_MSTAT, 32'h000C_3A51);
        rd_chk(ACL_OFS_INT_STAT, 32'h0000_0001);
        irq_chk(1'b1);
        wr(ACL_OFS_INT_STAT, 32'h0000_0001);
        irq_chk(1'b0);
        conclude();
    end
endmodule
